// ---- logic/cctr_pkg.sv ----
// Purpose: shared constants and types for the converter register bank
// Assumes: 20 MHz core clock, 8-bit registers on a byte-wide register port
// Notes: telemetry scale figures are kept for software and documentation of intent
package cctr_pkg;

  localparam logic [7:0] CCTR_DEV_ADDR_BYTE = 8'h60;

  localparam logic [7:0] CCTR_OFF_SETPOINT = 8'h00;
  localparam logic [7:0] CCTR_OFF_IND_RES = 8'h02;
  localparam logic [7:0] CCTR_OFF_SOFT_START = 8'h03;
  localparam logic [7:0] CCTR_OFF_VOUT_LOW = 8'h42;
  localparam logic [7:0] CCTR_OFF_VOUT_HIGH = 8'h43;
  localparam logic [7:0] CCTR_OFF_VIN = 8'h46;
  localparam logic [7:0] CCTR_OFF_IFAST = 8'h48;

  localparam logic [7:0] CCTR_RST_SETPOINT = 8'h46;
  localparam logic [3:0] CCTR_RST_IND_RES = 4'h0;
  localparam logic [2:0] CCTR_RST_SLEW = 3'h4;
  localparam logic [7:0] CCTR_RST_RESULT = 8'h00;
  localparam logic [11:0] CCTR_RST_RESULT12 = 12'h000;
  localparam logic [3:0] CCTR_RESERVED_NIBBLE = 4'h0;
  localparam logic [4:0] CCTR_RESERVED_CFG = 5'h00;
  localparam logic [7:0] CCTR_UNMAPPED_DATA = 8'h00;

  // field positions
  localparam int CCTR_IND_RES_LSB = 4;
  localparam int CCTR_SLEW_MSB = 2;

  // scale figures: setpoint step, result full scales
  localparam int CCTR_SETPOINT_STEP_MV = 10;
  localparam int CCTR_VOUT_FULL_MV = 2550;
  localparam int CCTR_VOUT_FULL_CODE = 4095;
  localparam int CCTR_VIN_FULL_MV = 20400;
  localparam int CCTR_VIN_FULL_CODE = 255;
  localparam int CCTR_IND_RES_BASE_UOHM = 14600;
  localparam int CCTR_IND_RES_STEP_UOHM = 800;

  // fast current refresh period
  localparam int CCTR_CLK_PERIOD_NS = 50;
  localparam int CCTR_IFAST_PERIOD_NS = 32000;
  localparam int CCTR_IFAST_CYCLES = CCTR_IFAST_PERIOD_NS / CCTR_CLK_PERIOD_NS;
  localparam int CCTR_IFAST_CW = 10;
  localparam logic [9:0] CCTR_IFAST_LAST = 10'(CCTR_IFAST_CYCLES - 1);

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cctr_req_t;

  typedef enum logic [1:0] {
    CCTR_LOCK_FREE = 2'b01,
    CCTR_LOCK_HELD = 2'b10
  } cctr_lock_t;

endpackage

// ---- logic/cctr_result_hold.sv ----
// Purpose: holds a 12-bit conversion result until both of its bytes were read
// Assumes: byte read pulses come from the register port, one cycle each
// Notes: a fresh sample offered while held is dropped, not queued
`timescale 1ns/1ps
module cctr_result_hold (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [11:0] sample_i,
  input wire logic sample_valid_i,
  input wire logic low_read_i,
  input wire logic high_read_i,
  output logic [11:0] result_o
);

  cctr_pkg::cctr_lock_t state;
  logic low_done;
  logic high_done;
  logic take;

  assign take = sample_valid_i && (state == cctr_pkg::CCTR_LOCK_FREE);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o <= cctr_pkg::CCTR_RST_RESULT12;
    end else if (ce_i && take) begin
      result_o <= sample_i;
    end
  end

  // a read in the load cycle belongs to the old value, so load clears both marks
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_done <= 1'b0;
      high_done <= 1'b0;
    end else if (ce_i) begin
      if (take) begin
        low_done <= 1'b0;
        high_done <= 1'b0;
      end else begin
        if (low_read_i) begin
          low_done <= 1'b1;
        end
        if (high_read_i) begin
          high_done <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= cctr_pkg::CCTR_LOCK_FREE;
    end else if (ce_i) begin
      case (state)
        cctr_pkg::CCTR_LOCK_FREE: begin
          if (take) begin
            state <= cctr_pkg::CCTR_LOCK_HELD; // RULE10
          end
        end
        cctr_pkg::CCTR_LOCK_HELD: begin
          if ((low_done || low_read_i) && (high_done || high_read_i)) begin
            state <= cctr_pkg::CCTR_LOCK_FREE; // RULE10
          end
        end
        default: begin
          state <= cctr_pkg::CCTR_LOCK_FREE;
        end
      endcase
    end
  end

endmodule

// ---- logic/cctr_regs.sv ----
// Purpose: register bank for converter settings and telemetry results
// Assumes: a serial front end decodes bytes and offers one-cycle register strobes
// Notes: reserved bits are not stored and read back as their initial zero
//
// Behaviour
// RULE1: the bank answers the address byte 0x60 with the direction bit in bit 0.
// RULE2: the host keeps reserved bits at their initial values when it writes.
// RULE3: the setpoint is read/write, resets to 0x46, and steps 10 mV per code.
// RULE4: bits 7:4 at 0x02 hold a read/write inductor resistance code, 14.6 to 26.6 mOhm.
// RULE5: the inductor resistance code is loaded with its production value at test.
// RULE6: bits 2:0 at 0x03 choose the slew rate, reset 100, halving per code.
// RULE7: bits 7:4 at 0x42 show the low four bits of the output voltage result.
// RULE8: the byte at 0x43 shows the high eight bits of the output voltage result.
// RULE9: the output voltage code is linear with 4095 at 2.55 V.
// RULE10: a 12-bit result stays frozen until both of its bytes were read.
// RULE11: the input voltage result sits at 0x46 and resets to zero.
// RULE12: the input voltage code is linear with 255 at 20.4 V.
// RULE13: the fast current result refreshes every 32 us.
// RULE14: writes to result registers are ignored.
`timescale 1ns/1ps
module cctr_regs (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_byte_i,
  output logic addr_match_o,
  input wire cctr_pkg::cctr_req_t req_i,
  output logic [7:0] rdata_o,
  input wire logic trim_load_i,
  input wire logic [3:0] trim_code_i,
  input wire logic [11:0] vout_sample_i,
  input wire logic vout_sample_valid_i,
  input wire logic [7:0] vin_sample_i,
  input wire logic vin_sample_valid_i,
  input wire logic [7:0] ifast_sample_i,
  output logic [7:0] output_voltage_setpoint_o,
  output logic [3:0] inductor_resistance_code_o,
  output logic [2:0] slew_select_o
);

  logic rst_meta;
  logic rst_n;
  logic [7:0] output_voltage_setpoint;
  logic [3:0] inductor_resistance_code;
  logic [2:0] slew_select;
  logic [11:0] output_voltage_result;
  logic [7:0] input_voltage_result;
  logic [7:0] fast_current_result;
  logic [9:0] ifast_count;
  logic low_read;
  logic high_read;
  logic [7:0] next_rdata;

  function automatic logic hit(input cctr_pkg::cctr_req_t r, input logic [7:0] off);
    hit = (r.addr == off);
  endfunction

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // the front end acks on this; both directions share the upper seven bits
  assign addr_match_o = (addr_byte_i[7:1] == cctr_pkg::CCTR_DEV_ADDR_BYTE[7:1]); // RULE1

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      output_voltage_setpoint <= cctr_pkg::CCTR_RST_SETPOINT; // RULE3
    end else if (ce_i && req_i.wr && hit(req_i, cctr_pkg::CCTR_OFF_SETPOINT)) begin
      output_voltage_setpoint <= req_i.wdata; // RULE3
    end
  end

  // production trim wins over a host write in the same cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      inductor_resistance_code <= cctr_pkg::CCTR_RST_IND_RES;
    end else if (ce_i) begin
      if (trim_load_i) begin
        inductor_resistance_code <= trim_code_i; // RULE5
      end else if (req_i.wr && hit(req_i, cctr_pkg::CCTR_OFF_IND_RES)) begin
        inductor_resistance_code <= req_i.wdata[7:cctr_pkg::CCTR_IND_RES_LSB]; // RULE4
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      slew_select <= cctr_pkg::CCTR_RST_SLEW;
    end else if (ce_i && req_i.wr && hit(req_i, cctr_pkg::CCTR_OFF_SOFT_START)) begin
      slew_select <= req_i.wdata[cctr_pkg::CCTR_SLEW_MSB:0]; // RULE6
    end
  end

  assign output_voltage_setpoint_o = output_voltage_setpoint;
  assign inductor_resistance_code_o = inductor_resistance_code;
  assign slew_select_o = slew_select;

  // only reads mark a byte as taken; writes to results touch nothing
  assign low_read = ce_i && req_i.rd && hit(req_i, cctr_pkg::CCTR_OFF_VOUT_LOW); // RULE14
  assign high_read = ce_i && req_i.rd && hit(req_i, cctr_pkg::CCTR_OFF_VOUT_HIGH);

  cctr_result_hold u_vout_hold (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .sample_i(vout_sample_i), // RULE9
    .sample_valid_i(vout_sample_valid_i),
    .low_read_i(low_read),
    .high_read_i(high_read),
    .result_o(output_voltage_result)
  );

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      input_voltage_result <= cctr_pkg::CCTR_RST_RESULT; // RULE11
    end else if (ce_i && vin_sample_valid_i) begin
      input_voltage_result <= vin_sample_i; // RULE12
    end
  end

  // free-running period; sampling is independent of host reads
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ifast_count <= '0;
      fast_current_result <= cctr_pkg::CCTR_RST_RESULT;
    end else if (ce_i) begin
      if (ifast_count == cctr_pkg::CCTR_IFAST_LAST) begin
        ifast_count <= '0;
        fast_current_result <= ifast_sample_i; // RULE13
      end else begin
        ifast_count <= ifast_count + 10'h001;
      end
    end
  end

  always_comb begin
    case (req_i.addr)
      cctr_pkg::CCTR_OFF_SETPOINT: next_rdata = output_voltage_setpoint;
      cctr_pkg::CCTR_OFF_IND_RES: next_rdata = {inductor_resistance_code,
                                               cctr_pkg::CCTR_RESERVED_NIBBLE};
      cctr_pkg::CCTR_OFF_SOFT_START: next_rdata = {cctr_pkg::CCTR_RESERVED_CFG, slew_select};
      cctr_pkg::CCTR_OFF_VOUT_LOW: next_rdata = {output_voltage_result[3:0],
                                                cctr_pkg::CCTR_RESERVED_NIBBLE}; // RULE7
      cctr_pkg::CCTR_OFF_VOUT_HIGH: next_rdata = output_voltage_result[11:4]; // RULE8
      cctr_pkg::CCTR_OFF_VIN: next_rdata = input_voltage_result;
      cctr_pkg::CCTR_OFF_IFAST: next_rdata = fast_current_result;
      default: next_rdata = cctr_pkg::CCTR_UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_o <= cctr_pkg::CCTR_UNMAPPED_DATA;
    end else if (ce_i && req_i.rd) begin
      rdata_o <= next_rdata;
    end
  end

endmodule

// ---- tb/cctr_regs_asserts.sv ----
// Purpose: port checks for the converter register bank
// Assumes: one clock domain, ce_i is part of every trigger except the address match check
// Notes: attached to the top module by bind
`timescale 1ns/1ps
module cctr_regs_asserts (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire logic [7:0] addr_byte_i,
  input wire logic addr_match_o,
  input wire cctr_pkg::cctr_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic trim_load_i,
  input wire logic [3:0] trim_code_i,
  input wire logic [7:0] vin_sample_i,
  input wire logic vin_sample_valid_i,
  input wire logic [7:0] output_voltage_setpoint_o,
  input wire logic [3:0] inductor_resistance_code_o,
  input wire logic [2:0] slew_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  wire logic wr_on = ce_i && req_i.wr;
  wire logic rd_on = ce_i && req_i.rd;
  property p_match; addr_match_o == (addr_byte_i[7:1] == 7'h30); endproperty
  a_match: assert property (p_match) else $error("address match wrong");
  property p_set; wr_on && req_i.addr == 8'h00 |=> output_voltage_setpoint_o == $past(req_i.wdata);
  endproperty
  a_set: assert property (p_set) else $error("setpoint write lost");
  property p_ro; wr_on && req_i.addr[7:4] == 4'h4 && !trim_load_i |=> $stable(slew_select_o)
    && $stable(output_voltage_setpoint_o) && $stable(inductor_resistance_code_o); endproperty
  a_ro: assert property (p_ro) else $error("result write changed a setting");
  property p_code; wr_on && req_i.addr == 8'h02 && !trim_load_i
    |=> inductor_resistance_code_o == $past(req_i.wdata[7:4]); endproperty
  a_code: assert property (p_code) else $error("resistance code write lost");
  property p_trim; ce_i && trim_load_i |=> inductor_resistance_code_o == $past(trim_code_i);
  endproperty
  a_trim: assert property (p_trim) else $error("trim load lost");
  property p_slew; wr_on && req_i.addr == 8'h03 |=> slew_select_o == $past(req_i.wdata[2:0]);
  endproperty
  a_slew: assert property (p_slew) else $error("slew write lost");
  property p_low; rd_on && req_i.addr == 8'h42 |=> rdata_o[3:0] == 4'h0; endproperty
  a_low: assert property (p_low) else $error("low result nibble not zero");
  property p_vin; ce_i && vin_sample_valid_i ##1 rd_on && req_i.addr == 8'h46 && !vin_sample_valid_i
    |=> rdata_o == $past(vin_sample_i, 2); endproperty
  a_vin: assert property (p_vin) else $error("input voltage read wrong");
endmodule
bind cctr_regs cctr_regs_asserts chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
  .addr_byte_i(addr_byte_i), .addr_match_o(addr_match_o), .req_i(req_i), .rdata_o(rdata_o),
  .trim_load_i(trim_load_i), .trim_code_i(trim_code_i), .vin_sample_i(vin_sample_i),
  .vin_sample_valid_i(vin_sample_valid_i), .output_voltage_setpoint_o(output_voltage_setpoint_o),
  .inductor_resistance_code_o(inductor_resistance_code_o), .slew_select_o(slew_select_o));

// ---- tb/cctr_host_model.sv ----
// Purpose: register-side stand-in for the serial bus host
// Assumes: each request is taken at the edge after it is raised
// Notes: released address and data are inverted so stale values never look valid; strobes drop to zero
`timescale 1ns/1ps
module cctr_host_model (
  input wire logic clk_i,
  output cctr_pkg::cctr_req_t req_o,
  output logic [7:0] addr_byte_o
);
  initial begin
    req_o = '0;
    addr_byte_o = 8'h60;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] m;
    m = (a == 8'h02) ? 8'hf0 : (a == 8'h03) ? 8'h07 : 8'hff;
    @(posedge clk_i);
    req_o <= {w, !w, a, d & m};
    @(posedge clk_i);
    req_o <= {2'b00, ~a, ~(d & m)};
  endtask
  // address byte changes on a clock edge, like every other host-driven field
  task automatic set_addr(input logic [7:0] b);
    @(posedge clk_i);
    addr_byte_o <= b;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the converter register bank
// Assumes: 20 MHz clock, ce_i high except in the clock-enable test at the end
// Notes: expectations come from an integer model of the bank
`timescale 1ns/1ps
module tb_top;
  logic clk_i, reset_n_i, trim_load_i, vout_valid, vin_valid, match, locked, ce;
  logic [3:0] trim_code_i, code;
  logic [2:0] slew;
  logic [11:0] vout_sample;
  logic [7:0] abyte, rdata, setpoint, vin_sample, ifast, a, d;
  cctr_pkg::cctr_req_t req;
  int mdl[256];
  int n_errors, tests_run, seed, mk, i;
  int cyc = 0;
  logic [7:0] offs[8] = '{8'h00, 8'h02, 8'h03, 8'h42, 8'h43, 8'h46, 8'h48, 8'h10};
  cctr_regs dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .addr_byte_i(abyte),
    .addr_match_o(match), .req_i(req), .rdata_o(rdata), .trim_load_i(trim_load_i),
    .trim_code_i(trim_code_i), .vout_sample_i(vout_sample), .vout_sample_valid_i(vout_valid),
    .vin_sample_i(vin_sample), .vin_sample_valid_i(vin_valid), .ifast_sample_i(ifast),
    .output_voltage_setpoint_o(setpoint), .inductor_resistance_code_o(code),
    .slew_select_o(slew));
  cctr_host_model host_u (.clk_i(clk_i), .req_o(req), .addr_byte_o(abyte));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] ra);
    host_u.xfer(1'b0, ra, 8'h00);
    #1;
    chk(rdata, mdl[ra][7:0]);
    if (ra == 8'h42) mk = mk | 1;
    if (ra == 8'h43) mk = mk | 2;
    if (mk == 3) locked = 1'b0;
  endtask
  task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
    host_u.xfer(1'b1, wa, wd);
    if (wa == 8'h00) mdl[0] = wd;
    if (wa == 8'h02) mdl[2] = wd & 8'hf0;
    if (wa == 8'h03) mdl[3] = wd & 8'h07;
  endtask
  task automatic vo(input logic [11:0] v);
    @(posedge clk_i);
    vout_sample <= v;
    vout_valid <= 1'b1;
    if (!locked) begin
      mdl[8'h42] = {v[3:0], 4'h0};
      mdl[8'h43] = v[11:4];
      locked = 1'b1;
      mk = 0;
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // strobes are one-cycle pulses, dropped at the edge after they rise
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (vout_valid) vout_valid <= 1'b0;
    if (vin_valid) vin_valid <= 1'b0;
    if (trim_load_i) trim_load_i <= 1'b0;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    finish_test;
  end
  initial begin
    {reset_n_i, trim_load_i, vout_valid, vin_valid, locked} = 5'h00;
    ce = 1'b1;
    trim_code_i = 4'h0;
    vout_sample = 12'h000;
    vin_sample = 8'h00;
    mk = 0;
    seed = 50342;
    ifast = 8'h5a;
    mdl[0] = 8'h46;
    mdl[3] = 8'h04;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (i = 0; i < 8; i++) rd(offs[i]);
    for (i = 0; i < 4; i++) begin
      host_u.set_addr(8'h60 + 8'(i));
      #1;
      chk({7'h0, match}, {7'h0, i < 2});
    end
    host_u.set_addr(8'h60);
    $display("test reset_and_address done");
    repeat (16) begin
      i = $random(seed);
      a = offs[i[2:0]];
      d = 8'($random(seed));
      wr(a, d);
      rd(a);
    end
    chk(setpoint, mdl[0][7:0]);
    chk({4'h0, code}, mdl[2][7:0] >> 4);
    chk({5'h0, slew}, mdl[3][7:0]);
    fork
      wr(8'h02, 8'h30);
      begin
        @(posedge clk_i);
        trim_code_i <= 4'hb;
        trim_load_i <= 1'b1;
      end
    join
    mdl[2] = 8'hb0;
    rd(8'h02);
    $display("test settings done");
    vo(12'habc);
    rd(8'h43);
    vo(12'h123);
    rd(8'h43);
    rd(8'h42);
    vo(12'h456);
    rd(8'h42);
    rd(8'h43);
    d = 8'($random(seed));
    @(posedge clk_i);
    vin_sample <= d;
    vin_valid <= 1'b1;
    mdl[8'h46] = d;
    rd(8'h46);
    $display("test results done");
    while (cyc < 640 || cyc % 640 != 300) @(posedge clk_i);
    ifast <= 8'hc3;
    mdl[8'h48] = 8'h5a;
    rd(8'h48);
    repeat (640) @(posedge clk_i);
    mdl[8'h48] = 8'hc3;
    rd(8'h48);
    $display("test fast_current done");
    // with the enable low neither a write nor a read may be taken
    @(posedge clk_i);
    ce <= 1'b0;
    host_u.xfer(1'b1, 8'h00, ~mdl[0][7:0]);
    host_u.xfer(1'b0, 8'h00, 8'h00);
    #1;
    chk(setpoint, mdl[0][7:0]);
    chk(rdata, mdl[8'h48][7:0]);
    @(posedge clk_i);
    ce <= 1'b1;
    rd(8'h00);
    $display("test clock_enable done");
    finish_test;
  end
endmodule
